// ===== hdl/csr_regs.vh
`ifndef CSR_REGS_VH
`define CSR_REGS_VH
// data-space and io-space addresses
`define CSR_STATUS_DADDR 8'h5F
`define CSR_IO_OFFSET 8'h20
`define CSR_STATUS_IOADDR 6'h3F
`define CSR_SP_LO_DADDR 8'h5D
`define CSR_SP_HI_DADDR 8'h5E
`define CSR_GPR_LAST 8'h1F
// first register of the pointer pairs
`define CSR_PTR_BASE 5'h1A
// status bit positions
`define CSR_BIT_I 7
`define CSR_BIT_T 6
`define CSR_BIT_H 5
`define CSR_BIT_S 4
`define CSR_BIT_V 3
`define CSR_BIT_N 2
`define CSR_BIT_Z 1
`define CSR_BIT_C 0
// reset values
`define CSR_STATUS_RST 8'h00
`define CSR_SP_RST 11'h4FF
// stack pointer operations
`define CSR_SP_NONE 3'h0
`define CSR_SP_PUSH 3'h1
`define CSR_SP_POP 3'h2
`define CSR_SP_CALL 3'h3
`define CSR_SP_RET 3'h4
// pointer modes
`define CSR_PM_DISP 2'h0
`define CSR_PM_INC 2'h1
`define CSR_PM_DEC 2'h2
`endif

// ===== hdl/csr_core_state.v
`timescale 1ns/1ps
// Functional notes
// (RULE_01) status never saved or restored on interrupts
// (RULE_02) status at 0x5F data, 0x3F io
// (RULE_03) global enable zero blocks all interrupts; a request held through entry is granted once more
// (RULE_04) enable cleared on entry, set on return
// (RULE_05) bit 6 is bit-copy store
// (RULE_06) bit 5 records nibble half carry
// (RULE_07) bit 4 equals negative xor overflow
// (RULE_08) bit 3 records two's complement overflow
// (RULE_09) bits 2,1,0 negative, zero, carry
// (RULE_10) four read/write register file patterns
// (RULE_11) registers mapped at data 0x00-0x1F
// (RULE_12) registers 26-31 form three pointers
// (RULE_13) pointers support displacement, increment, decrement
// (RULE_14) stack grows downward, pointer marks top
// (RULE_15) push minus one, pop plus one
// (RULE_16) calls minus two, returns plus two
// (RULE_17) stack pointer resets to last SRAM
// (RULE_18) software sets stack before calls
// (RULE_19) 11-bit stack pointer at 0x5D/0x5E
// (RULE_20) software status write beats hardware update
`include "csr_regs.vh"
module csr_core_state #(
   parameter SP_W = 11,
   parameter SP_RESET = `CSR_SP_RST
) (
   input wire clk,
   input wire arst_n,
   // register file ports
   input wire [4:0] rd_a_sel,
   input wire [4:0] rd_b_sel,
   input wire wr8_en,
   input wire [4:0] wr8_sel,
   input wire [7:0] wr8_data,
   input wire wr16_en,
   input wire [4:0] wr16_sel,
   input wire [15:0] wr16_data,
   output reg [7:0] rd_a_data,
   output reg [7:0] rd_b_data,
   output reg [15:0] rd_w_data,
   // pointer unit
   input wire ptr_en,
   input wire [1:0] ptr_sel,
   input wire [1:0] ptr_mode,
   input wire [5:0] ptr_disp,
   output reg [15:0] ptr_addr,
   // data space access
   input wire ds_wr,
   input wire ds_rd,
   input wire [15:0] ds_addr,
   input wire [7:0] ds_wdata,
   output reg [7:0] ds_rdata,
   output reg ds_hit,
   // io space access
   input wire io_wr,
   input wire io_rd,
   input wire [5:0] io_addr,
   input wire [7:0] io_wdata,
   // flag updates from alu
   input wire [7:0] flag_we,
   input wire [7:0] flag_val,
   input wire bit_to_flag_instr,
   input wire [2:0] bit_sel,
   input wire [7:0] bit_src,
   input wire flag_to_bit_instr,
   input wire [4:0] bit_dst_sel,
   // interrupt and stack control
   input wire irq_taken,
   input wire interrupt_return_instr,
   input wire sei_instr,
   input wire cli_instr,
   input wire irq_req,
   input wire [2:0] sp_op,
   output reg irq_go,
   output reg [7:0] core_status_flags,
   output reg [SP_W-1:0] stack_ptr
);
   reg [7:0] gpr [0:31];
   reg [7:0] status_nxt;
   reg [SP_W-1:0] sp_nxt;
   reg [15:0] ptr_nxt;
   reg [15:0] ptr_cur;
   reg [7:0] ds_rd_nxt;
   reg ds_hit_nxt;
   wire [7:0] io_daddr;
   wire [4:0] ptr_lo_idx;
   wire [4:0] ptr_hi_idx;
   wire status_ds_hit;
   wire status_io_hit;
   wire sp_lo_ds_hit;
   wire sp_lo_io_hit;
   wire sp_hi_ds_hit;
   wire sp_hi_io_hit;
   wire gpr_ds_hit;
   wire status_sw_wr;
   wire sp_lo_wr;
   wire sp_hi_wr;
   wire [7:0] sp_lo_wdata;
   wire [7:0] sp_hi_wdata;
   integer i;

   // (RULE_02) io address plus offset gives data address
   assign io_daddr = {2'b00, io_addr} + `CSR_IO_OFFSET;
   // one decode per register and space, shared by reads and writes
   assign status_ds_hit = (ds_addr == {8'h00, `CSR_STATUS_DADDR});
   assign status_io_hit = (io_daddr == `CSR_STATUS_DADDR);
   // (RULE_19) stack pointer byte decode
   assign sp_lo_ds_hit = (ds_addr == {8'h00, `CSR_SP_LO_DADDR});
   assign sp_lo_io_hit = (io_daddr == `CSR_SP_LO_DADDR);
   assign sp_hi_ds_hit = (ds_addr == {8'h00, `CSR_SP_HI_DADDR});
   assign sp_hi_io_hit = (io_daddr == `CSR_SP_HI_DADDR);
   // (RULE_11) working registers in the low 32 addresses
   assign gpr_ds_hit = (ds_addr <= {8'h00, `CSR_GPR_LAST});

   // software write strobes, data and io space merged
   assign status_sw_wr = (ds_wr && status_ds_hit) || (io_wr && status_io_hit);
   assign sp_lo_wr = (ds_wr && sp_lo_ds_hit) || (io_wr && sp_lo_io_hit);
   assign sp_hi_wr = (ds_wr && sp_hi_ds_hit) || (io_wr && sp_hi_io_hit);
   // io data only when the io write hits this byte itself
   // a data write may meet an io write to another register
   assign sp_lo_wdata = (io_wr && sp_lo_io_hit) ? io_wdata : ds_wdata;
   assign sp_hi_wdata = (io_wr && sp_hi_io_hit) ? io_wdata : ds_wdata;

   // (RULE_12) pointer pair, low register holds low byte
   // select code 3 wraps to registers 0 and 1; decoder never issues it
   assign ptr_lo_idx = `CSR_PTR_BASE + {2'b00, ptr_sel, 1'b0};
   assign ptr_hi_idx = {ptr_lo_idx[4:1], 1'b1};

   // status next value; hardware sources layered, software last
   always @* begin
      status_nxt = core_status_flags;
      for (i = 0; i < 8; i = i + 1) begin
         // (RULE_06) (RULE_08) (RULE_09) alu flag loads
         if (flag_we[i]) begin
            status_nxt[i] = flag_val[i];
         end
      end
      // (RULE_07) sign tracks negative xor overflow
      if (flag_we[`CSR_BIT_N] || flag_we[`CSR_BIT_V]) begin
         status_nxt[`CSR_BIT_S] = status_nxt[`CSR_BIT_N] ^ status_nxt[`CSR_BIT_V];
      end
      // (RULE_05) copy selected bit into store
      if (bit_to_flag_instr) begin
         status_nxt[`CSR_BIT_T] = bit_src[bit_sel];
      end
      // (RULE_04) hardware enable control
      if (sei_instr || interrupt_return_instr) begin
         status_nxt[`CSR_BIT_I] = 1'b1;
      end
      if (cli_instr || irq_taken) begin
         status_nxt[`CSR_BIT_I] = 1'b0;
      end
      // (RULE_01) entry and return touch only the enable bit
      // (RULE_20) software write overrides everything
      if (io_wr && status_io_hit) begin
         status_nxt = io_wdata;
      end else if (status_sw_wr) begin
         status_nxt = ds_wdata;
      end
   end

   // stack pointer next value
   always @* begin
      sp_nxt = stack_ptr;
      case (sp_op)
         // (RULE_15) single byte push and pop
         `CSR_SP_PUSH: sp_nxt = stack_ptr - {{(SP_W-1){1'b0}}, 1'b1};
         `CSR_SP_POP: sp_nxt = stack_ptr + {{(SP_W-1){1'b0}}, 1'b1};
         // (RULE_16) return address is two bytes
         `CSR_SP_CALL: sp_nxt = stack_ptr - {{(SP_W-2){1'b0}}, 2'b10};
         `CSR_SP_RET: sp_nxt = stack_ptr + {{(SP_W-2){1'b0}}, 2'b10};
         default: sp_nxt = stack_ptr;
      endcase
      // software load wins; limitation: a bus write and a push collide
      if (sp_lo_wr) begin
         sp_nxt[7:0] = sp_lo_wdata;
      end
      if (sp_hi_wr) begin
         sp_nxt[SP_W-1:8] = sp_hi_wdata[SP_W-9:0];
      end
   end

   // pointer arithmetic on the selected pair
   always @* begin
      ptr_cur = {gpr[ptr_hi_idx], gpr[ptr_lo_idx]};
      ptr_nxt = ptr_cur;
      // (RULE_13) displacement, post increment, pre decrement
      case (ptr_mode)
         `CSR_PM_DISP: ptr_nxt = ptr_cur + {10'h000, ptr_disp};
         `CSR_PM_INC: ptr_nxt = ptr_cur + 16'h0001;
         `CSR_PM_DEC: ptr_nxt = ptr_cur - 16'h0001;
         default: ptr_nxt = ptr_cur;
      endcase
   end

   // data space read mux
   always @* begin
      ds_rd_nxt = 8'h00;
      ds_hit_nxt = 1'b0;
      // (RULE_11) register file read through data space
      if (ds_rd && gpr_ds_hit) begin
         ds_rd_nxt = gpr[ds_addr[4:0]];
         ds_hit_nxt = 1'b1;
      end else if ((ds_rd && status_ds_hit) ||
                   (io_rd && status_io_hit)) begin
         ds_rd_nxt = core_status_flags;
         ds_hit_nxt = 1'b1;
      end else if ((ds_rd && sp_lo_ds_hit) ||
                   (io_rd && sp_lo_io_hit)) begin
         ds_rd_nxt = stack_ptr[7:0];
         ds_hit_nxt = 1'b1;
      end else if ((ds_rd && sp_hi_ds_hit) ||
                   (io_rd && sp_hi_io_hit)) begin
         // (RULE_19) upper bits read zero
         ds_rd_nxt = {{(16-SP_W){1'b0}}, stack_ptr[SP_W-1:8]};
         ds_hit_nxt = 1'b1;
      end
   end

   // (RULE_02) status clears at reset
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         core_status_flags <= `CSR_STATUS_RST;
      end else begin
         core_status_flags <= status_nxt;
      end
   end

   // (RULE_17) stack starts at last sram byte
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stack_ptr <= SP_RESET;
      end else begin
         // (RULE_14) downward growing stack pointer
         stack_ptr <= sp_nxt;
      end
   end

   // (RULE_03) global enable gates requests
   // a cli_instr clear in the same cycle blocks too; the entry clear by irq_taken does not, so a held request can grant once more
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_go <= 1'b0;
      end else begin
         irq_go <= irq_req && core_status_flags[`CSR_BIT_I] && !cli_instr;
      end
   end

   // read result stands one cycle after the strobe
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ds_rdata <= 8'h00;
         ds_hit <= 1'b0;
      end else begin
         ds_rdata <= ds_rd_nxt;
         ds_hit <= ds_hit_nxt;
      end
   end

   // decrement and displacement use the computed address, increment uses current
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_addr <= 16'h0000;
      end else if (ptr_en) begin
         ptr_addr <= (ptr_mode == `CSR_PM_INC) ? ptr_cur : ptr_nxt;
      end
   end

   // (RULE_10) read ports registered
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_a_data <= 8'h00;
         rd_b_data <= 8'h00;
         rd_w_data <= 16'h0000;
      end else begin
         rd_a_data <= gpr[rd_a_sel];
         rd_b_data <= gpr[rd_b_sel];
         rd_w_data <= {gpr[{rd_a_sel[4:1], 1'b1}], gpr[{rd_a_sel[4:1], 1'b0}]};
      end
   end

   // register array; no reset so it maps to plain storage
   always @(posedge clk) begin
      // (RULE_10) 8-bit and 16-bit result writes
      if (wr16_en) begin
         gpr[{wr16_sel[4:1], 1'b0}] <= wr16_data[7:0];
         gpr[{wr16_sel[4:1], 1'b1}] <= wr16_data[15:8];
      end
      if (wr8_en) begin
         gpr[wr8_sel] <= wr8_data;
      end
      // (RULE_05) store bit back into a register
      if (flag_to_bit_instr) begin
         gpr[bit_dst_sel][bit_sel] <= core_status_flags[`CSR_BIT_T];
      end
      // (RULE_13) pointer writeback on increment or decrement
      if (ptr_en && ptr_mode != `CSR_PM_DISP) begin
         gpr[ptr_lo_idx] <= ptr_nxt[7:0];
         gpr[ptr_hi_idx] <= ptr_nxt[15:8];
      end
      // (RULE_11) data-space store into the register file
      if (ds_wr && gpr_ds_hit) begin
         gpr[ds_addr[4:0]] <= ds_wdata;
      end
   end
endmodule // csr_core_state

// ===== verification/csr_core_state_sva.sv
`timescale 1ns/1ps
// port-level checks of stack, status and interrupt gating
module csr_core_state_sva (
   input wire clk,
   input wire arst_n,
   input wire ds_wr,
   input wire io_wr,
   input wire [15:0] ds_addr,
   input wire [7:0] ds_wdata,
   input wire [7:0] flag_we,
   input wire irq_taken,
   input wire interrupt_return_instr,
   input wire cli_instr,
   input wire [2:0] sp_op,
   input wire irq_go,
   input wire [7:0] core_status_flags,
   input wire [10:0] stack_ptr
);
   // software writes win over hardware, so they mask the stack, enable and sign checks
   wire sw = ds_wr | io_wr;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_push; sp_op == 3'h1 && !sw |=> stack_ptr == $past(stack_ptr) - 11'h1; endproperty
   a_push: assert property (p_push) else $error("push step wrong");
   property p_pop; sp_op == 3'h2 && !sw |=> stack_ptr == $past(stack_ptr) + 11'h1; endproperty
   a_pop: assert property (p_pop) else $error("pop step wrong");
   property p_call; sp_op == 3'h3 && !sw |=> stack_ptr == $past(stack_ptr) - 11'h2; endproperty
   a_call: assert property (p_call) else $error("call step wrong");
   property p_ret; sp_op == 3'h4 && !sw |=> stack_ptr == $past(stack_ptr) + 11'h2; endproperty
   a_ret: assert property (p_ret) else $error("return step wrong");
   property p_block; !core_status_flags[7] |=> !irq_go; endproperty
   a_block: assert property (p_block) else $error("grant while disabled");
   property p_enter; irq_taken && !sw |=> !core_status_flags[7]; endproperty
   a_enter: assert property (p_enter) else $error("enable kept on entry");
   property p_interrupt_return_instr; interrupt_return_instr && !irq_taken && !cli_instr && !sw |=> core_status_flags[7];
   endproperty
   a_interrupt_return_instr: assert property (p_interrupt_return_instr) else $error("enable not set on return");
   property p_sign; (flag_we[3] || flag_we[2]) && !sw |=> core_status_flags[4] ==
      (core_status_flags[3] ^ core_status_flags[2]); endproperty
   a_sign: assert property (p_sign) else $error("sign not n xor v");
   property p_swr; ds_wr && ds_addr == 16'h005F && !io_wr |=> core_status_flags == $past(ds_wdata);
   endproperty
   a_swr: assert property (p_swr) else $error("status write lost");
   c_call: cover property (sp_op == 3'h3);
   c_take: cover property (irq_taken);
   c_swr: cover property (ds_wr && ds_addr == 16'h005F);
endmodule // csr_core_state_sva
bind csr_core_state csr_core_state_sva u_csr_core_state_sva (.*);

// ===== verification/csr_irq_seq.sv
`timescale 1ns/1ps
// interrupt sequencer model: answers a grant with a one-cycle entry pulse
module csr_irq_seq (
   input wire clk,
   input wire arst_n,
   input wire irq_go,
   output reg irq_taken
);
   // a held grant yields pulses a cycle apart, as the real sequencer may
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) irq_taken <= 1'b0;
      else irq_taken <= irq_go & !irq_taken;
   end
endmodule // csr_irq_seq

// ===== verification/csr_core_state_tb_top.sv
`timescale 1ns/1ps
module csr_core_state_tb_top;
   reg clk = 0, arst_n = 0, wr8_en = 0, wr16_en = 0, ptr_en = 0, ds_wr = 0, ds_rd = 0, io_wr = 0;
   reg io_rd = 0, bit_to_flag_instr = 0, flag_to_bit_instr = 0, irq_req = 0;
   reg interrupt_return_instr = 0, sei_instr = 0, cli_instr = 0;
   reg [4:0] rd_a_sel = 0, rd_b_sel = 0, wr8_sel = 0, wr16_sel = 0, bit_dst_sel = 0;
   reg [7:0] wr8_data = 0, ds_wdata = 0, io_wdata = 0, flag_we = 0, flag_val = 0, bit_src = 0;
   reg [15:0] wr16_data = 0, ds_addr = 0;
   reg [1:0] ptr_sel = 0, ptr_mode = 0;
   reg [5:0] ptr_disp = 0, io_addr = 0;
   reg [2:0] bit_sel = 0, sp_op = 0;
   wire [7:0] rd_a_data, rd_b_data, ds_rdata, core_status_flags;
   wire [15:0] rd_w_data, ptr_addr;
   wire ds_hit, irq_go, irq_taken;
   wire [10:0] stack_ptr;
   logic [10:0] spx [4] = '{11'h4FE, 11'h4FF, 11'h4FD, 11'h4FF};
   int fail_count = 0, check_count = 0, cyc = 0, i;
   // read result captured while it stands, one cycle after the strobe
   reg [7:0] rd_seen = 0;
   reg hit_seen = 0;
   csr_core_state u_csr_core_state (.*);
   csr_irq_seq u_csr_irq_seq (.clk(clk), .arst_n(arst_n), .irq_go(irq_go), .irq_taken(irq_taken));
   always #5 clk = ~clk;
   // hang guard, far above the roughly 72 cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count = fail_count + 1;
         test_done;
      end
   end
   task test_done;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input string n, input [15:0] e, input [15:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fail_count = fail_count + 1;
         end
      end
   endtask
   // one request cycle, strobes dropped, then an idle cycle so no signal moves twice a step
   task nx;
      begin
         @(negedge clk);
         {wr8_en, wr16_en, ptr_en, ds_wr, ds_rd, io_wr, bit_to_flag_instr} = 0;
         {flag_to_bit_instr, interrupt_return_instr, sei_instr, cli_instr} = 0;
         flag_we = 0;
         sp_op = 0;
         @(negedge clk);
      end
   endtask
   task dw(input [15:0] a, input [7:0] d);
      begin
         ds_wr = 1;
         ds_addr = a;
         ds_wdata = d;
         nx;
      end
   endtask
   // io selects the io space; result taken at the edge it stands
   task dr(input io, input [15:0] a);
      begin
         if (io) begin
            io_rd = 1;
            io_addr = a[5:0];
         end else begin
            ds_rd = 1;
            ds_addr = a;
         end
         @(negedge clk);
         ds_rd = 0;
         io_rd = 0;
         rd_seen = ds_rdata;
         hit_seen = ds_hit;
         @(negedge clk);
      end
   endtask
   initial begin
      repeat (8) @(negedge clk);
      arst_n = 1;
      chk("status", 8'h00, core_status_flags);
      chk("sp", 11'h4FF, stack_ptr);
      dw(16'h005F, 8'hA5);
      chk("status", 8'hA5, core_status_flags);
      io_wr = 1;
      io_addr = 6'h3F;
      io_wdata = 8'h5A;
      flag_we = 8'hFF;
      nx;
      chk("status", 8'h5A, core_status_flags);
      dr(1'b0, 16'h005F);
      chk("rdata", 8'h5A, rd_seen);
      chk("hit", 1'b1, hit_seen);
      dr(1'b1, 16'h003F);
      chk("io rdata", 8'h5A, rd_seen);
      dr(1'b0, 16'h0060);
      chk("hit", 1'b0, hit_seen);
      chk("rdata", 8'h00, rd_seen);
      $display("status test done");
      dw(16'h001A, 8'h34);
      dw(16'h001B, 8'h12);
      {wr16_en, wr16_sel, wr16_data, wr8_en, wr8_sel, wr8_data} = {1'b1, 5'd28, 16'hBEEF, 14'h2000};
      rd_a_sel = 5'd26;
      rd_b_sel = 5'd29;
      nx;
      chk("rd_a", 8'h34, rd_a_data);
      chk("rd_w", 16'h1234, rd_w_data);
      chk("rd_b", 8'hBE, rd_b_data);
      {ptr_en, ptr_sel, ptr_mode} = 5'b10001;
      nx;
      chk("ptr inc", 16'h1234, ptr_addr);
      {ptr_en, ptr_mode} = 3'b110;
      nx;
      chk("ptr dec", 16'h1234, ptr_addr);
      {ptr_en, ptr_mode, ptr_disp} = {3'b100, 6'd5};
      nx;
      chk("ptr disp", 16'h1239, ptr_addr);
      flag_we = 8'h0C;
      flag_val = 8'h04;
      nx;
      chk("flags", 8'h56, core_status_flags);
      {bit_to_flag_instr, bit_src, bit_sel} = {1'b1, 8'h7F, 3'd7};
      nx;
      chk("t clear", 8'h16, core_status_flags);
      {bit_to_flag_instr, bit_src, bit_sel} = {1'b1, 8'h01, 3'd0};
      nx;
      chk("t set", 8'h56, core_status_flags);
      {flag_to_bit_instr, bit_sel, rd_a_sel} = {1'b1, 3'd7, 5'd0};
      nx;
      chk("bit load", 8'h80, rd_a_data);
      $display("register file test done");
      dw(16'h005D, 8'hFF);
      dw(16'h005E, 8'h04);
      dr(1'b0, 16'h005E);
      chk("sp high read", 8'h04, rd_seen);
      for (i = 0; i < 4; i++) begin
         sp_op = 3'(i + 1);
         nx;
         chk("sp step", spx[i], stack_ptr);
      end
      dw(16'h005E, 8'hFF);
      chk("sp high", 11'h7FF, stack_ptr);
      dr(1'b0, 16'h005E);
      chk("sp high read", 8'h07, rd_seen);
      dr(1'b0, 16'h005D);
      chk("sp low read", 8'hFF, rd_seen);
      $display("stack test done");
      irq_req = 1;
      nx;
      chk("blocked", 1'b0, irq_go);
      sei_instr = 1;
      nx;
      chk("grant", 1'b1, irq_go);
      irq_req = 0;
      nx;
      chk("entry", 8'h56, core_status_flags);
      interrupt_return_instr = 1;
      nx;
      chk("return", 8'hD6, core_status_flags);
      cli_instr = 1;
      nx;
      chk("cli", 8'h56, core_status_flags);
      $display("interrupt test done");
      {flag_we, flag_val} = {8'h21, 8'h21};
      nx;
      chk("half carry", 8'h77, core_status_flags);
      {flag_we, flag_val} = {8'h1C, 8'h1C};
      nx;
      chk("sign", 8'h6F, core_status_flags);
      $display("flag test done");
      test_done;
   end
endmodule // csr_core_state_tb_top
